// File: rw_buffer_controller.sv
// Purpose: orders processor reads and writes to a slower main memory
//          through small read and write buffers
// Assumes: processor and memory run on ref_clk; memory acks two
//          cycles after a request
// Notes:   TWO_DEEP_WRITE selects one-deep read/two-deep write,
//          otherwise two-deep read/one-deep write
//
// Behaviour
// - a read waits for the memory acknowledge of every buffered write
// - address capture stays off for a pending read until write completes
// - one-deep write mode: one-word write buffer; back-to-back second write stalls the processor
// - stalled second write is taken in the fixup cycle after retirement
// - request pulse for stalled second write only in the fixup cycle
// - one-deep write mode: no capture of a following write's address or data during a write
// - write during streaming with write busy aborts streaming, runs at fixup
// - write interrupting streaming raises write ongoing only in fixup
// - address and data of a streaming write captured only after streaming
// - two-deep read mode queues memory read data in two registers
// - two-deep read mode passes write data through one register
// - two-deep read mode generates even parity in both directions
// - two-deep write mode passes read address and type through one register
// - two-deep write mode returns read data via one register, parity added
// - two-deep write mode queues write address and data in two registers
// - single-entry writes, like peripheral writes, may use the one-deep path
// - with two writes buffered access type bits are queued alongside
// - write busy while a write is in progress or a read is pending
// - read busy held for the whole of a write
// - a lone write completes from request to release in three cycles
`timescale 1ns/10ps
`default_nettype none
`include "buffer_regs.svh"

module rw_buffer_controller #(
  parameter bit TWO_DEEP_WRITE = 1'b0
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               clk_en,
  input  wire logic               cpu_read_pending,
  input  wire logic               cpu_write_request,
  input  wire logic               cpu_streaming,
  input  wire logic               cpu_single_entry,
  input  wire buffer_pkg::req_s   cpu_req,
  input  wire logic [`DATA_W-1:0] cpu_wdata,
  input  wire logic               cpu_rready,
  input  wire logic               memory_cycle_done_ack,
  input  wire logic [`DATA_W-1:0] mem_rdata,
  output logic                    write_stall_flag,
  output logic                    read_stall_flag,
  output logic                    write_ongoing,
  output logic                    memory_request_pulse,
  output logic                    mem_write,
  output logic                    address_capture_enable,
  output logic                    stream_abort,
  output buffer_pkg::req_s        mem_req,
  output buffer_pkg::word_s       mem_wword,
  output logic                    cpu_rvalid,
  output buffer_pkg::word_s       cpu_rword
);

  // ==========================================================
  // effective depths per configuration
  localparam logic [`CNT_W-1:0] WR_DEPTH =
    TWO_DEEP_WRITE ? `DEPTH_TWO : `DEPTH_ONE;
  localparam logic [`CNT_W-1:0] RD_DEPTH =
    TWO_DEEP_WRITE ? `DEPTH_ONE : `DEPTH_TWO;
  localparam int NSLOT = 2;

  typedef logic [`CNT_W-1:0] cnt_t;

  // ==========================================================
  // state
  buffer_pkg::state_e    state_ff;
  buffer_pkg::state_e    nxt_state;
  buffer_pkg::wentry_s   wq_ff     [NSLOT];
  buffer_pkg::wentry_s   nxt_wq    [NSLOT];
  buffer_pkg::word_s     rq_ff     [NSLOT];
  buffer_pkg::word_s     nxt_rq    [NSLOT];
  logic [`CNT_W-1:0]     wq_cnt_ff;
  logic [`CNT_W-1:0]     nxt_wq_cnt;
  logic [`CNT_W-1:0]     rq_cnt_ff;
  logic [`CNT_W-1:0]     nxt_rq_cnt;
  logic                  rd_done_ff;
  logic                  nxt_rd_done;
  logic                  wr_from_q_ff;
  logic                  write_stall_ff;
  logic                  read_stall_ff;
  logic                  write_ongoing_ff;
  logic                  req_pulse_ff;
  logic                  mem_write_ff;
  logic                  ace_ff;
  logic                  abort_ff;
  logic                  rvalid_ff;
  buffer_pkg::req_s      mem_req_ff;
  buffer_pkg::word_s     mem_wword_ff;

  // ==========================================================
  // even parity, one bit per byte, both directions
  logic [`PAR_W-1:0] wpar;
  logic [`PAR_W-1:0] rpar;

  genvar b;
  generate
    for (b = 0; b < `PAR_W; b++) begin : g_par
      assign wpar[b] = ^cpu_wdata[b*`BYTE_W +: `BYTE_W];
      assign rpar[b] = ^mem_rdata[b*`BYTE_W +: `BYTE_W];
    end
  endgenerate

  buffer_pkg::wentry_s win;
  buffer_pkg::word_s   rin;

  assign win.req       = cpu_req;   // type bits ride with the entry
  assign win.word.data = cpu_wdata;
  assign win.word.par  = wpar;
  assign rin.data      = mem_rdata;
  assign rin.par       = rpar;

  // ==========================================================
  // decode
  wire is_idle = (state_ff == buffer_pkg::ST_IDLE);
  wire is_wr   = (state_ff == buffer_pkg::ST_WR);
  wire is_rd   = (state_ff == buffer_pkg::ST_RD);

  // peripheral writes fall back to a single slot
  wire [`CNT_W-1:0] wr_limit =
    cpu_single_entry ? `DEPTH_ONE : WR_DEPTH;

  wire wr_pop  = is_wr & memory_cycle_done_ack;
  wire rd_push = is_rd & memory_cycle_done_ack;
  wire rd_pop  = rvalid_ff & cpu_rready;

  // a write is never taken while streaming or while a read holds the
  // shared data buffer; a full buffer stalls until the ack frees it
  // a write sent straight from the processor fills a slot while in flight
  wire [`CNT_W-1:0] wr_used =
    wq_cnt_ff + ((is_wr & ~wr_from_q_ff) ? `CNT_STEP : `CNT_ZERO);
  wire wr_room = (wr_used < wr_limit);
  wire accept_wr = cpu_write_request & wr_room & ~cpu_streaming
                   & ~is_rd & ~(cpu_read_pending & ~rd_done_ff);

  // abort a streaming write that meets an active write busy
  wire nxt_abort = cpu_streaming & cpu_write_request
                   & write_stall_ff;

  // writes drain first; reads wait for the write's ack
  wire wr_queued = (wq_cnt_ff != `CNT_ZERO);
  wire start_wr  = is_idle & (wr_queued | accept_wr);
  wire rd_room   = (rq_cnt_ff < RD_DEPTH);
  wire start_rd  = is_idle & ~start_wr & cpu_read_pending
                   & ~rd_done_ff & rd_room;

  // entry presented to memory at write start
  wire buffer_pkg::wentry_s wr_head = wr_queued ? wq_ff[0] : win;

  // ==========================================================
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      buffer_pkg::ST_IDLE: begin
        if (start_wr) begin
          nxt_state = buffer_pkg::ST_WR;
        end else if (start_rd) begin
          nxt_state = buffer_pkg::ST_RD;
        end
      end
      buffer_pkg::ST_WR: begin
        if (memory_cycle_done_ack) begin
          nxt_state = buffer_pkg::ST_IDLE;
        end
      end
      buffer_pkg::ST_RD: begin
        if (memory_cycle_done_ack) begin
          nxt_state = buffer_pkg::ST_IDLE;
        end
      end
      default: nxt_state = buffer_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // write queue: shift on pop, push behind the survivors
  // an entry started straight from the processor is not queued
  wire wr_push = accept_wr & ~(start_wr & ~wr_queued);
  // only a write that left from the queue frees a queue slot at its ack
  wire wr_deq  = wr_pop & wr_from_q_ff;
  wire [`CNT_W-1:0] wr_slot =
    wr_deq ? (wq_cnt_ff - `CNT_STEP) : wq_cnt_ff;

  genvar i;
  generate
    for (i = 0; i < NSLOT; i++) begin : g_wq
      buffer_pkg::wentry_s shifted;
      if (i + 1 < NSLOT) begin : g_mid
        assign shifted = wr_deq ? wq_ff[i+1] : wq_ff[i];
      end else begin : g_last
        assign shifted = wq_ff[i];
      end
      assign nxt_wq[i] = (wr_push && wr_slot == cnt_t'(i))
                         ? win : shifted;
    end
  endgenerate

  assign nxt_wq_cnt = wr_slot + (wr_push ? `CNT_STEP : `CNT_ZERO);

  // ==========================================================
  // read queue toward the processor
  wire [`CNT_W-1:0] rd_slot =
    rd_pop ? (rq_cnt_ff - `CNT_STEP) : rq_cnt_ff;

  generate
    for (i = 0; i < NSLOT; i++) begin : g_rq
      buffer_pkg::word_s shifted;
      if (i + 1 < NSLOT) begin : g_mid
        assign shifted = rd_pop ? rq_ff[i+1] : rq_ff[i];
      end else begin : g_last
        assign shifted = rq_ff[i];
      end
      assign nxt_rq[i] = (rd_push && rd_slot == cnt_t'(i))
                         ? rin : shifted;
    end
  endgenerate

  assign nxt_rq_cnt = rd_slot + (rd_push ? `CNT_STEP : `CNT_ZERO);

  // one word per pending read; cleared when the processor drops it
  assign nxt_rd_done = cpu_read_pending & (rd_done_ff | rd_push);

  // ==========================================================
  // flag next values
  wire nxt_wr_busy   = (nxt_state == buffer_pkg::ST_WR);
  wire nxt_ongoing   = nxt_wr_busy;
  // busy covers a queued write too, so a late read cannot slip in
  wire write_pending = nxt_wr_busy | (nxt_wq_cnt != `CNT_ZERO);
  wire nxt_wstall    = write_pending | (cpu_read_pending & ~nxt_rd_done)
                       | ~(nxt_wq_cnt < wr_limit);
  wire nxt_rstall    = write_pending
                       | (cpu_read_pending & ~nxt_rd_done);
  // capture pulses once per write, held through a read
  wire nxt_ace       = start_wr | start_rd | (is_rd & ~memory_cycle_done_ack);

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff         <= buffer_pkg::ST_IDLE;
      wq_cnt_ff        <= `CNT_ZERO;
      rq_cnt_ff        <= `CNT_ZERO;
      rd_done_ff       <= 1'b0;
      write_stall_ff   <= 1'b0;
      read_stall_ff    <= 1'b0;
      write_ongoing_ff <= 1'b0;
      req_pulse_ff     <= 1'b0;
      mem_write_ff     <= 1'b0;
      ace_ff           <= 1'b0;
      abort_ff         <= 1'b0;
      wr_from_q_ff     <= 1'b0;
      rvalid_ff        <= 1'b0;
    end else if (clk_en) begin
      state_ff         <= nxt_state;
      wq_cnt_ff        <= nxt_wq_cnt;
      rq_cnt_ff        <= nxt_rq_cnt;
      rd_done_ff       <= nxt_rd_done;
      write_stall_ff   <= nxt_wstall;
      read_stall_ff    <= nxt_rstall;
      write_ongoing_ff <= nxt_ongoing;
      req_pulse_ff     <= start_wr | start_rd;
      mem_write_ff     <= nxt_wr_busy;
      ace_ff           <= nxt_ace;
      abort_ff         <= nxt_abort;
      wr_from_q_ff     <= start_wr ? wr_queued : wr_from_q_ff;
      rvalid_ff        <= (nxt_rq_cnt != `CNT_ZERO);
    end
  end

  // data registers carry no reset; their valids guard them
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      for (int k = 0; k < NSLOT; k++) begin
        wq_ff[k] <= nxt_wq[k];
        rq_ff[k] <= nxt_rq[k];
      end
    end
  end

  // address and type go out through one register for either access
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (start_wr) begin
        mem_req_ff   <= wr_head.req;
        mem_wword_ff <= wr_head.word;
      end else if (start_rd) begin
        mem_req_ff   <= cpu_req;
      end
    end
  end

  // ==========================================================
  // outputs
  assign write_stall_flag       = write_stall_ff;
  assign read_stall_flag        = read_stall_ff;
  assign write_ongoing          = write_ongoing_ff;
  assign memory_request_pulse   = req_pulse_ff;
  assign mem_write              = mem_write_ff;
  assign address_capture_enable = ace_ff;
  assign stream_abort           = abort_ff;
  assign mem_req                = mem_req_ff;
  assign mem_wword              = mem_wword_ff;
  assign cpu_rvalid             = rvalid_ff;
  assign cpu_rword              = rq_ff[0];

endmodule
`default_nettype wire

// File: buffer_regs.svh
// Purpose: named constants for the read/write buffer controller
// Assumes: included by its bare name wherever a constant is needed
// Notes:   definitions only
`ifndef BUFFER_REGS_SVH
`define BUFFER_REGS_SVH

// ==========================================================
// widths
`define ADDR_W      32
`define DATA_W      32
`define ACC_W       2
`define BYTE_W      8
`define PAR_W       4
`define CNT_W       2

// ==========================================================
// depths and counts
`define DEPTH_ONE   2'h1
`define DEPTH_TWO   2'h2
`define CNT_ZERO    2'h0
`define CNT_STEP    2'h1

`endif

// File: buffer_pkg.sv
// Purpose: shared types of the read/write buffer controller
// Assumes: buffer_regs.svh holds the widths
// Notes:   no constants live here, only types
`include "buffer_regs.svh"

package buffer_pkg;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`ACC_W-1:0]  acctype;
  } req_s;

  typedef struct packed {
    logic [`DATA_W-1:0] data;
    logic [`PAR_W-1:0]  par;
  } word_s;

  typedef struct packed {
    req_s  req;
    word_s word;
  } wentry_s;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WR   = 3'h2,
    ST_RD   = 3'h4
  } state_e;

endpackage

// File: rw_buffer_controller_sva.sv
// Purpose: protocol checker for rw_buffer_controller
// Assumes: one-deep write mode, clk_en held high
// Notes:   attached to every controller instance by bind
`timescale 1ns/10ps
`default_nettype none

module rw_buffer_controller_sva (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cpu_streaming,
  input wire logic cpu_write_request,
  input wire logic memory_cycle_done_ack,
  input wire logic write_stall_flag,
  input wire logic read_stall_flag,
  input wire logic write_ongoing,
  input wire logic memory_request_pulse,
  input wire logic mem_write,
  input wire logic address_capture_enable,
  input wire logic stream_abort,
  input wire logic cpu_rvalid
);
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_PULSE_ONE: assert property (
    memory_request_pulse |=> !memory_request_pulse)
    else $error("request pulse too long");
  AST_WR_START: assert property (memory_request_pulse && mem_write
    |-> write_ongoing && address_capture_enable) else $error("bad write start");
  AST_WIP_SPAN: assert property (
    $rose(write_ongoing) |-> write_ongoing[*3])
    else $error("write cycle too short");
  // a fixup write restarts two cycles after the ack at the earliest, so write_ongoing always drops first
  AST_WIP_END: assert property (
    write_ongoing && memory_cycle_done_ack
    |=> !write_ongoing || memory_request_pulse) else $error("write not ended");
  AST_NO_REQ: assert property (
    write_ongoing && !memory_cycle_done_ack
    |=> !memory_request_pulse) else $error("request during write");
  AST_NO_CAPT: assert property (
    write_ongoing && !memory_cycle_done_ack
    |=> !address_capture_enable) else $error("capture during write");
  AST_BUSY: assert property (write_ongoing
    |-> write_stall_flag && read_stall_flag) else $error("busy low in write");
  AST_RD_DATA: assert property (
    memory_cycle_done_ack && !mem_write
    |=> cpu_rvalid) else $error("read word missing");
  AST_ABORT: assert property (cpu_streaming && cpu_write_request
    && write_stall_flag |=> stream_abort) else $error("no stream abort");
  AST_STREAM_WIP: assert property (cpu_streaming
    |=> !$rose(write_ongoing)) else $error("write began in stream");
  AST_RESET: assert property (
    disable iff (1'b0) srst |=> !write_ongoing
    && !memory_request_pulse && !write_stall_flag && !read_stall_flag)
    else $error("reset state wrong");
endmodule

bind rw_buffer_controller rw_buffer_controller_sva chk (
  .ref_clk(ref_clk), .srst(srst), .cpu_streaming(cpu_streaming),
  .cpu_write_request(cpu_write_request), .mem_write(mem_write),
  .memory_cycle_done_ack(memory_cycle_done_ack),
  .write_stall_flag(write_stall_flag), .read_stall_flag(read_stall_flag),
  .write_ongoing(write_ongoing), .memory_request_pulse(memory_request_pulse),
  .address_capture_enable(address_capture_enable),
  .stream_abort(stream_abort), .cpu_rvalid(cpu_rvalid));
`default_nettype wire

// File: mem_model.sv
// Purpose: slow main memory answering the controller
// Assumes: one request per pulse
// Notes:   read word is built from the address
`timescale 1ns/10ps
`default_nettype none
`include "buffer_regs.svh"

module mem_model (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              memory_request_pulse,
  input  wire buffer_pkg::req_s  mem_req,
  output logic                   memory_cycle_done_ack,
  output logic [`DATA_W-1:0]     mem_rdata
);
  // ==========================================================
  // fixed two-cycle answer
  logic [1:0]         due_ff;
  logic [`DATA_W-1:0] rd_ff;

  assign memory_cycle_done_ack = due_ff[1];
  assign mem_rdata = rd_ff;

  // outside the ack cycle the bus toggles, so a stale word never matches
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      due_ff <= 2'h0;
      rd_ff  <= 32'h0;
    end else begin
      due_ff <= {due_ff[0], memory_request_pulse};
      rd_ff  <= due_ff[0] ? {mem_req.addr[15:0], ~mem_req.addr[15:0]} : ~rd_ff;
    end
  end
endmodule
`default_nettype wire

// File: rw_buffer_controller_tb.sv
// Purpose: self-checking bench for rw_buffer_controller
// Assumes: one-deep write mode, mem_model as memory
// Notes:   inputs change at rising edges, outputs read at falling edges
`timescale 1ns/10ps
`default_nettype none

module rw_buffer_controller_tb;
  // ==========================================================
  // stimulus and wiring
  logic ref_clk, srst = 1'b1, clk_en = 1'b1, cpu_single_entry = 1'b0;
  logic cpu_read_pending = 1'b0, cpu_write_request = 1'b0;
  logic cpu_streaming = 1'b0, cpu_rready = 1'b0;
  logic [31:0] cpu_wdata = 32'h0;
  buffer_pkg::req_s cpu_req = '0;
  logic ack, write_stall_flag, read_stall_flag, write_ongoing, mem_write;
  logic memory_request_pulse, address_capture_enable, stream_abort;
  logic cpu_rvalid;
  logic [31:0] mem_rdata;
  buffer_pkg::req_s mem_req;
  buffer_pkg::word_s mem_wword, cpu_rword;
  int errors = 0, cmp_count = 0, cyc = 0;

  rw_buffer_controller dut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .cpu_read_pending(cpu_read_pending), .cpu_write_request(cpu_write_request),
    .cpu_streaming(cpu_streaming), .cpu_single_entry(cpu_single_entry),
    .cpu_req(cpu_req), .cpu_wdata(cpu_wdata), .cpu_rready(cpu_rready),
    .memory_cycle_done_ack(ack), .mem_rdata(mem_rdata),
    .write_stall_flag(write_stall_flag), .read_stall_flag(read_stall_flag),
    .write_ongoing(write_ongoing), .memory_request_pulse(memory_request_pulse),
    .mem_write(mem_write), .address_capture_enable(address_capture_enable),
    .stream_abort(stream_abort), .mem_req(mem_req), .mem_wword(mem_wword),
    .cpu_rvalid(cpu_rvalid), .cpu_rword(cpu_rword));
  mem_model mem (.ref_clk(ref_clk), .srst(srst), .mem_req(mem_req),
    .memory_request_pulse(memory_request_pulse),
    .memory_cycle_done_ack(ack), .mem_rdata(mem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ==========================================================
  // helpers
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic buffer_pkg::word_s mk_word(input logic [31:0] d);
    mk_word.data = d;
    for (int b = 0; b < 4; b++) mk_word.par[b] = ^d[8*b +: 8];
  endfunction
  // which: 0 request pulse, 1 memory ack, 2 read word valid
  task automatic wait_for(input int which);
    int n;
    logic s;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      s = which == 0 ? memory_request_pulse : which == 1 ? ack : cpu_rvalid;
    end while (s !== 1'b1 && n < 20);
    check(n < 20, 1'b1);
  endtask
  task automatic drive_wr(input logic [31:0] a, input logic [31:0] d);
    cpu_req <= '{addr: a, acctype: 2'h1};
    cpu_wdata <= d;
    cpu_write_request <= 1'b1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_lone();
    int n;
    @(posedge ref_clk);
    drive_wr(32'h0000_1234, 32'h8001_ff00);
    wait_for(0);
    check({write_ongoing, write_stall_flag, read_stall_flag, mem_write},
          4'hf);
    check(mem_wword, mk_word(32'h8001_ff00));
    @(posedge ref_clk);
    cpu_write_request <= 1'b0;
    n = 1;
    @(negedge ref_clk);
    while (write_ongoing === 1'b1 && n < 8) begin
      n++;
      @(negedge ref_clk);
    end
    check(n, 3);
  endtask
  task automatic t_b2b();
    int ta;
    @(posedge ref_clk);
    drive_wr(32'h0000_2000, 32'h1111_2222);
    @(posedge ref_clk);
    drive_wr(32'h0000_2004, 32'h3333_4444);
    wait_for(1);
    ta = cyc;
    check({mem_req.addr, mem_wword},
          {32'h2000, mk_word(32'h1111_2222)});
    @(negedge ref_clk);
    check(write_stall_flag, 1'b0);
    wait_for(0);
    check(cyc > ta, 1'b1);
    check({mem_req.addr, mem_wword},
          {32'h2004, mk_word(32'h3333_4444)});
    @(posedge ref_clk);
    cpu_write_request <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic t_rd();
    int ta;
    @(posedge ref_clk);
    drive_wr(32'h0000_3000, 32'h5555_6666);
    @(posedge ref_clk);
    cpu_write_request <= 1'b0;
    cpu_read_pending <= 1'b1;
    cpu_req <= '{addr: 32'h0a5c, acctype: 2'h0};
    wait_for(1);
    ta = cyc;
    wait_for(0);
    check(cyc > ta, 1'b1);
    check({address_capture_enable, mem_req.addr},
          {1'b1, 32'h0a5c});
    wait_for(2);
    check(cpu_rword, mk_word(32'h0a5c_f5a3));
    @(posedge ref_clk);
    cpu_read_pending <= 1'b0;
    @(posedge ref_clk);
    cpu_read_pending <= 1'b1;
    cpu_req <= '{addr: 32'hc3a0, acctype: 2'h0};
    wait_for(1);
    @(posedge ref_clk);
    cpu_read_pending <= 1'b0;
    cpu_rready <= 1'b1;
    @(posedge ref_clk);
    cpu_rready <= 1'b0;
    @(negedge ref_clk);
    check({cpu_rvalid, cpu_rword},
          {1'b1, mk_word(32'hc3a0_3c5f)});
    @(posedge ref_clk);
    cpu_rready <= 1'b1;
    @(posedge ref_clk);
    cpu_rready <= 1'b0;
    @(negedge ref_clk);
    check(cpu_rvalid, 1'b0);
  endtask
  task automatic t_stream();
    @(posedge ref_clk);
    cpu_streaming <= 1'b1;
    cpu_read_pending <= 1'b1;
    cpu_req <= '{addr: 32'h4000, acctype: 2'h2};
    wait_for(0);
    @(posedge ref_clk);
    drive_wr(32'h0000_5000, 32'h7777_8888);
    @(posedge ref_clk);
    @(negedge ref_clk);
    check({stream_abort, write_ongoing}, 2'h2);
    wait_for(2);
    @(posedge ref_clk);
    {cpu_streaming, cpu_read_pending, cpu_rready} <= 3'h1;
    wait_for(0);
    check({write_ongoing, mem_req.addr}, {1'b1, 32'h5000});
    check(mem_wword, mk_word(32'h7777_8888));
    @(posedge ref_clk);
    {cpu_write_request, cpu_rready} <= 2'h0;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check({write_ongoing, write_stall_flag, read_stall_flag,
           memory_request_pulse, cpu_rvalid, stream_abort}, 6'h0);
    t_lone();
    t_b2b();
    t_rd();
    t_stream();
    repeat (8) @(posedge ref_clk);
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
